// ===== hw/frwc_flash_row_write_controller.v
// flash row write controller: latches, unlock, row program, config space access
`include "frwc_regs.vh"
`default_nettype none
module frwc_flash_row_write_controller #(
	parameter LATCH_BITS = 4,
	parameter ROWS       = 32,
	parameter PROG_CYCLES = `FRWC_PROG_NS / `FRWC_CLK_NS
) (
	input  wire        core_clk_i,
	input  wire        reset_n_i,
	input  wire [13:0] prog_addr_i,
	input  wire [13:0] prog_data_i,
	input  wire        unlock_write_i,
	input  wire [7:0]  unlock_data_i,
	input  wire        write_start_i,
	input  wire        read_start_i,
	input  wire        erase_select_i,
	input  wire        write_enable_i,
	input  wire        latch_only_select_i,
	input  wire        config_space_select_i,
	input  wire [13:0] devid_i,
	input  wire [13:0] cfgword_i,
	output reg  [13:0] read_data_o,
	output reg         read_valid_o,
	output reg         core_stall_o,
	output reg         busy_o,
	output reg         op_done_o
);
	localparam LATCHES   = 1 << LATCH_BITS;
	localparam RB        = `FRWC_ADDR_MSB + 1 - LATCH_BITS;
	localparam WORDS     = ROWS * LATCHES;
	localparam W         = `FRWC_WORD_BITS;
	localparam UIDS      = `FRWC_UID_WORDS;
	localparam [31:0] PROG_LOAD = PROG_CYCLES;
	localparam ST_IDLE   = 2'h0;
	localparam ST_NOP    = 2'h1;
	localparam ST_PROG   = 2'h2;
	localparam ST_DONE   = 2'h3;
	localparam KEY_NONE  = 2'h0;
	localparam KEY_HALF  = 2'h1;
	localparam KEY_FULL  = 2'h2;

	reg  [13:0]           flash_mem [0:WORDS-1];
	reg  [13:0]           uid_mem [0:UIDS-1];
	reg  [1:0]            key_r;
	reg  [1:0]            key_nxt;
	reg  [1:0]            state_r;
	reg  [1:0]            nop_r;
	reg  [31:0]           prog_cnt_r;
	reg                   is_prog_r;
	reg                   is_erase_r;
	reg                   cfg_r;
	reg  [13:0]           addr_r;
	reg  [13:0]           rd_word;
	wire [W*LATCHES-1:0]  latch_flat;
	wire [LATCH_BITS-1:0] latch_sel;
	wire [RB-1:0]         row_hold;
	wire                  idle;
	wire                  unlocked;
	wire                  accept;
	wire                  load_en;
	wire                  blank_en;
	wire                  uid_rd;
	wire                  uid_hit;
	integer               i;

	assign latch_sel = prog_addr_i[LATCH_BITS-1:0];
	assign row_hold  = addr_r[`FRWC_ADDR_MSB:LATCH_BITS];
	assign idle      = (state_r == ST_IDLE);
	assign unlocked  = (key_r == KEY_FULL) && write_start_i && write_enable_i;
	assign accept    = idle && !read_start_i && unlocked;
	assign load_en   = accept && !erase_select_i;
	assign blank_en  = (state_r == ST_DONE) && is_prog_r;
	assign uid_rd    = (prog_addr_i >= `FRWC_CFG_BASE) && (prog_addr_i <= `FRWC_UID_LAST);
	assign uid_hit   = (addr_r >= `FRWC_CFG_BASE) && (addr_r <= `FRWC_UID_LAST);

	// unlock key tracking; anything out of order drops the key
	always @* begin
		key_nxt = key_r;
		if (write_start_i || read_start_i) begin
			key_nxt = KEY_NONE;
		end else if (unlock_write_i) begin
			if (key_r == KEY_NONE && unlock_data_i == `FRWC_KEY1) begin
				key_nxt = KEY_HALF;
			end else if (key_r == KEY_HALF && unlock_data_i == `FRWC_KEY2) begin
				key_nxt = KEY_FULL;
			end else begin
				key_nxt = KEY_NONE;
			end
		end
	end

	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			key_r <= KEY_NONE;
		end else begin
			key_r <= key_nxt;
		end
	end

	// read source select
	always @* begin
		rd_word = `FRWC_ZERO_WORD;
		if (!config_space_select_i) begin
			rd_word = flash_mem[prog_addr_i[`FRWC_ADDR_MSB:0]];
		end else if (uid_rd) begin
			rd_word = uid_mem[prog_addr_i[`FRWC_UID_MSB:0]];
		end else if (prog_addr_i == `FRWC_DEVID) begin
			rd_word = devid_i;
		end else if (prog_addr_i == `FRWC_CFGWORD) begin
			rd_word = cfgword_i;
		end
	end

	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			read_data_o  <= `FRWC_ZERO_WORD;
			read_valid_o <= 1'b0;
		end else if (idle && read_start_i) begin
			read_data_o  <= rd_word;
			read_valid_o <= 1'b1;
		end else begin
			read_valid_o <= 1'b0;
		end
	end

	// operation sequencer
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_r    <= ST_IDLE;
			nop_r      <= `FRWC_NOP_NONE;
			prog_cnt_r <= `FRWC_CNT_NONE;
			is_prog_r  <= 1'b0;
			is_erase_r <= 1'b0;
			cfg_r      <= 1'b0;
			addr_r     <= `FRWC_ZERO_WORD;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						addr_r     <= prog_addr_i;
						cfg_r      <= config_space_select_i;
						is_erase_r <= erase_select_i;
						is_prog_r  <= erase_select_i || !latch_only_select_i;
						nop_r      <= `FRWC_NOP_CYCLES;
						state_r    <= ST_NOP;
					end
				end
				ST_NOP: begin
					nop_r <= nop_r - `FRWC_NOP_STEP;
					if (nop_r == `FRWC_NOP_STEP) begin
						prog_cnt_r <= PROG_LOAD;
						if (is_prog_r) begin
							state_r <= ST_PROG;
						end else begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_PROG: begin
					prog_cnt_r <= prog_cnt_r - `FRWC_CNT_STEP;
					if (prog_cnt_r <= `FRWC_CNT_STEP) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// stall, busy and done flags
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			core_stall_o <= 1'b0;
			busy_o       <= 1'b0;
			op_done_o    <= 1'b0;
		end else begin
			op_done_o <= (state_r == ST_DONE);
			if (accept) begin
				core_stall_o <= 1'b1;
				busy_o       <= 1'b1;
			end else if (state_r == ST_DONE) begin
				core_stall_o <= 1'b0;
				busy_o       <= 1'b0;
			end
		end
	end

	// write latches, one per word of a row
	genvar g;
	generate
		for (g = 0; g < LATCHES; g = g + 1) begin : g_latch
			localparam [LATCH_BITS-1:0] IDX = g;
			reg [13:0] word_r;
			always @(posedge core_clk_i) begin
				if (!reset_n_i) begin
					word_r <= `FRWC_BLANK;
				end else if (blank_en) begin
					word_r <= `FRWC_BLANK;
				end else if (load_en && latch_sel == IDX) begin
					word_r <= prog_data_i;
				end
			end
			assign latch_flat[g*W +: W] = word_r;
		end
	endgenerate

	// array commit, only into the held row; no erase on program
	always @(posedge core_clk_i) begin
		if (blank_en && !cfg_r) begin
			for (i = 0; i < LATCHES; i = i + 1) begin
				if (is_erase_r) begin
					flash_mem[{row_hold, i[LATCH_BITS-1:0]}] <= `FRWC_BLANK;
				end else begin
					flash_mem[{row_hold, i[LATCH_BITS-1:0]}] <=
						flash_mem[{row_hold, i[LATCH_BITS-1:0]}] &
						latch_flat[i*W +: W];
				end
			end
		end else if (blank_en && uid_hit) begin
			for (i = 0; i < UIDS; i = i + 1) begin
				if (is_erase_r) begin
					uid_mem[i] <= `FRWC_BLANK;
				end else begin
					uid_mem[i] <= uid_mem[i] & latch_flat[i*W +: W];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== hw/frwc_regs.vh
// constants for the flash row write controller
// Notes on behaviour
// - upper address bits pick row, low bits latch
// - one operation writes only the addressed row
// - latches return to 0x3fff after write/erase
// - unloaded latches stay blank and program blank
// - program never erases the row first
// - at most one row of latches per write
// - latch-only set: unlock loads latch only
// - latch-only clear: load last word, program row
// - broken unlock sequence starts nothing
// - config select redirects to top-bit region
// - forbidden config read clears data pair
// - user id words readable and writable
// - id and config word read-only
// - unlock is 55h, aah, then write-start
// - two no-op cycles; row write stalls core
`ifndef FRWC_REGS_VH
`define FRWC_REGS_VH
`define FRWC_KEY1        8'h55
`define FRWC_KEY2        8'haa
`define FRWC_BLANK       14'h3fff
`define FRWC_UID_LAST    14'h2003
`define FRWC_DEVID       14'h2006
`define FRWC_CFGWORD     14'h2007
`define FRWC_CFG_BASE    14'h2000
`define FRWC_NOP_CYCLES  2'h2
`define FRWC_PROG_NS     2000000
`define FRWC_CLK_NS      20
`define FRWC_ADDR_MSB    8
`define FRWC_WORD_BITS   14
`define FRWC_UID_WORDS   4
`define FRWC_UID_MSB     1
`define FRWC_ZERO_WORD   14'h0000
`define FRWC_NOP_NONE    2'h0
`define FRWC_NOP_STEP    2'h1
`define FRWC_CNT_NONE    32'h00000000
`define FRWC_CNT_STEP    32'h00000001
`endif

// ===== testbench/frwc_sva.sv
// port assertions for the flash row write controller
`default_nettype none
module frwc_sva #(parameter PROG_CYCLES = 10) (
	input wire logic core_clk_i, reset_n_i, unlock_write_i, write_start_i, read_start_i,
	input wire logic write_enable_i, latch_only_select_i, config_space_select_i,
	input wire logic core_stall_o, busy_o, op_done_o, read_valid_o,
	input wire logic [7:0] unlock_data_i,
	input wire logic [13:0] prog_addr_i, read_data_o);
	localparam int PA = PROG_CYCLES + 2, PB = PROG_CYCLES + 3;
	logic [1:0] k_r;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge core_clk_i)
		if (!reset_n_i || read_start_i || write_start_i) k_r <= 2'h0;
		else if (unlock_write_i) k_r <= {k_r[0] && unlock_data_i == 8'haa, unlock_data_i == 8'h55};
	property p_st; busy_o == core_stall_o; endproperty
	a_st: assert property (p_st) else $error("stall");
	property p_we; write_start_i && !write_enable_i && !busy_o |=> !busy_o; endproperty
	a_we: assert property (p_we) else $error("no enable");
	property p_ky; write_start_i && !k_r[1] && !busy_o |=> !busy_o; endproperty
	a_ky: assert property (p_ky) else $error("no key");
	property p_ld; $rose(busy_o) && $past(latch_only_select_i) |-> busy_o[*3] ##1 op_done_o;
		endproperty
	a_ld: assert property (p_ld) else $error("load time");
	property p_pg; $rose(busy_o) && !$past(latch_only_select_i) |-> ##[PA:PB] op_done_o;
		endproperty
	a_pg: assert property (p_pg) else $error("program time");
	property p_dn; op_done_o |-> !busy_o ##1 !op_done_o; endproperty
	a_dn: assert property (p_dn) else $error("done");
	property p_rd; read_start_i && !busy_o |=> read_valid_o; endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_cf; read_start_i && !busy_o && config_space_select_i && prog_addr_i == 14'h2005
		|=> read_data_o == 14'h0; endproperty
	a_cf: assert property (p_cf) else $error("zero");
	c_ld: cover property (p_ld);
	c_pg: cover property (p_pg);
	c_cf: cover property (p_cf);
endmodule
bind frwc_flash_row_write_controller frwc_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.*);
`default_nettype wire

// ===== testbench/frwc_sw.sv
// software model: unlock writes, start and read pulses
`default_nettype none
module frwc_sw (
	input wire logic clk_i,
	output var logic uw_o, ws_o, rs_o,
	output var logic [7:0] ud_o);
	timeunit 1ns; timeprecision 1ps;
	initial {uw_o, ws_o, rs_o, ud_o} = 11'h0;
	task automatic unl(input logic [7:0] d);
		@(negedge clk_i) {uw_o, ud_o} <= {1'b1, d};
		@(negedge clk_i) {uw_o, ud_o} <= {1'b0, ~d};
	endtask
	task automatic go(input logic [7:0] k);
		unl(8'h55);
		unl(k);
		@(negedge clk_i) ws_o <= 1'b1;
		@(negedge clk_i) ws_o <= 1'b0;
	endtask
	task automatic rd;
		@(negedge clk_i) rs_o <= 1'b1;
		@(negedge clk_i) rs_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// bench for the flash row write controller
`default_nettype none
module tb_top;
	timeunit 1ns; timeprecision 1ps;
	logic core_clk_i = 0, reset_n_i = 0, write_enable_i = 1, latch_only_select_i = 0;
	logic config_space_select_i = 0, erase_select_i = 1, unlock_write_i, write_start_i;
	logic read_start_i, read_valid_o, core_stall_o, busy_o, op_done_o;
	logic [7:0] unlock_data_i;
	logic [13:0] prog_addr_i = 14'h40, prog_data_i = 0, devid_i = 0, cfgword_i = 0, read_data_o;
	logic [13:0] d [16] = '{default: 14'h3fff};
	logic [15:0] lf = 16'h4380;
	int errors = 0, num_checks = 0, n, i;
	frwc_sw sw (.clk_i(core_clk_i), .uw_o(unlock_write_i), .ws_o(write_start_i),
		.rs_o(read_start_i), .ud_o(unlock_data_i));
	frwc_flash_row_write_controller #(.PROG_CYCLES(10)) dut (.*);
	initial forever #10 core_clk_i = ~core_clk_i;
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string s, input logic [13:0] g, e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic op(input logic [7:0] k, input logic ok);
		sw.go(k);
		for (n = 0; n < 40 && op_done_o !== 1'b1; n++) @(negedge core_clk_i);
		chk("op_done_o", 14'(n < 40), 14'(ok));
	endtask
	task automatic rd(input logic [13:0] a, e);
		prog_addr_i = a;
		sw.rd;
		@(negedge core_clk_i) chk("read_data_o", read_data_o, e);
	endtask
	initial begin
		repeat (20) @(negedge core_clk_i);
		reset_n_i = 1;
		op(8'haa, 1);
		erase_select_i = 0;
		for (i = 0; i < 16; i += 3) begin
			lf = nx(lf);
			{prog_addr_i, prog_data_i, d[i]} = {14'h40 + 14'(i), lf[13:0], lf[13:0]};
			latch_only_select_i = i < 15;
			op(8'haa, 1);
		end
		for (i = 0; i < 16; i++) rd(14'h40 + 14'(i), d[i]);
		prog_addr_i = 14'h40;
		prog_data_i = 0;
		write_enable_i = 0;
		op(8'haa, 0);
		write_enable_i = 1;
		op(8'h5a, 0);
		prog_data_i = lf[15:2];
		d[0] &= prog_data_i;
		op(8'haa, 1);
		for (i = 0; i < 16; i++) rd(14'h40 + 14'(i), d[i]);
		lf = nx(lf);
		d[2] = lf[13:0];
		erase_select_i = 1;
		op(8'haa, 1);
		erase_select_i = 0;
		for (i = 0; i < 16; i++) begin
			{prog_addr_i, prog_data_i} = {14'h40 + 14'(i), d[i]};
			latch_only_select_i = i < 15;
			op(8'haa, 1);
		end
		for (i = 0; i < 16; i++) rd(14'h40 + 14'(i), d[i]);
		{config_space_select_i, devid_i, cfgword_i} = {1'b1, lf[13:0], ~lf[13:0]};
		rd(14'h2006, devid_i);
		rd(14'h2007, cfgword_i);
		rd(14'h2005, 14'h0);
		prog_addr_i = 14'h2001;
		erase_select_i = 1;
		op(8'haa, 1);
		erase_select_i = 0;
		prog_addr_i = 14'h2001;
		prog_data_i = lf[15:2];
		op(8'haa, 1);
		rd(14'h2001, prog_data_i);
		rd(14'h2000, 14'h3fff);
		prog_addr_i = 14'h2006;
		op(8'haa, 1);
		rd(14'h2006, devid_i);
		rd(14'h2001, prog_data_i);
		finish_test;
	end
endmodule
`default_nettype wire
